// ---- inc/csc_pkg.sv ----
// Shared constants and types for the clock synthesizer control block
package csc_pkg;

    // Control register layout
    localparam int CTL_W = 16;
    localparam int PRESCALE_BIT = 15;
    localparam int DIVIDER_BIT = 14;
    localparam int MOD_LSB = 8;
    localparam int MOD_W = 6;
    localparam int LOCK_BIT = 3;
    localparam logic [CTL_W-1:0] CTL_RESET = 16'h3F00;

    // Multiplier output width: 4 * 64 * 2^3 = 2048 needs 12 bits
    localparam int MULT_W = 12;
    localparam int MULT_BASE_SHIFT = 2;

    // Feedback prescaler: three bits, W=0 divides by 2, W=1 by 8
    localparam int PRE_W = 3;
    localparam logic [PRE_W-1:0] PRE_LAST_W0 = 3'h1;
    localparam logic [PRE_W-1:0] PRE_LAST_W1 = 3'h7;

    // Relock time, counted in reference clock edges
    localparam int LOCK_REF_EDGES = 16;
    localparam int LOCK_CNT_W = 5;

    // Divider for the system clock from the oscillator stand-in
    localparam int DIV_W = 2;

    // Programmed synthesizer settings
    typedef struct packed {
        logic prescale;
        logic divider;
        logic [MOD_W-1:0] modulus;
    } csc_ctl_s;

    // Loop state, one-hot
    typedef enum logic [2:0] {
        ST_RELOCK = 3'b001,
        ST_LOCKED = 3'b010,
        ST_BYPASS = 3'b100
    } csc_state_e;

endpackage

// ---- design/csc_top.sv ----
// Clock synthesizer control: settings register, feedback divider, lock and reset hold
`timescale 1ns/1ps
module csc_top
    import csc_pkg::*;
(
    input wire logic clock_i, // 100 MHz clock, oscillator stand-in
    input wire logic rst_b_i, // Synchronous reset, active low
    input wire logic clock_mode_pin_i, // Clock mode strap pin
    input wire logic ref_clock_in_i, // Reference clock pin
    input wire logic ext_sys_clock_i, // External system clock pin
    input wire logic ctl_wr_i, // Control register write strobe
    input wire logic [CTL_W-1:0] ctl_wdata_i, // Control register write data
    output logic [CTL_W-1:0] ctl_rdata_o, // Control register read data
    output logic synth_lock_flag_o, // Synthesizer locked
    output logic synth_enabled_o, // Mode captured at reset was synthesize
    output logic chip_reset_b_o, // Chip reset hold, active low
    output logic sys_clock_o, // System clock
    output logic fb_pulse_o, // Feedback divider output pulse
    output logic [MULT_W-1:0] mult_o // Reference to system clock multiplier
);

    // Pin synchronisers
    logic mode_s1_reg, mode_s2_reg;
    logic ref_s1_reg, ref_s2_reg, ref_d_reg;
    logic ext_s1_reg, ext_s2_reg;

    always_ff @(posedge clock_i) begin
        mode_s1_reg <= clock_mode_pin_i;
        mode_s2_reg <= mode_s1_reg;
        ref_s1_reg <= ref_clock_in_i;
        ref_s2_reg <= ref_s1_reg;
        ref_d_reg <= ref_s2_reg;
        ext_s1_reg <= ext_sys_clock_i;
        ext_s2_reg <= ext_s1_reg;
    end

    logic ref_edge;
    assign ref_edge = ref_s2_reg & ~ref_d_reg;

    // Strap: follows the pin while reset is held, frozen after release
    logic synth_mode_reg, synth_mode_next;

    always_comb begin
        synth_mode_next = synth_mode_reg;
        if (!rst_b_i) begin
            synth_mode_next = mode_s2_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        synth_mode_reg <= synth_mode_next;
    end

    // Control register; writes ignored in bypass so clock never moves
    csc_ctl_s ctl_reg, ctl_next, ctl_wr;
    logic loop_change;

    always_comb begin
        ctl_wr.prescale = ctl_wdata_i[PRESCALE_BIT];
        ctl_wr.divider = ctl_wdata_i[DIVIDER_BIT];
        ctl_wr.modulus = ctl_wdata_i[MOD_LSB +: MOD_W];
        ctl_next = ctl_reg;
        loop_change = 1'b0;
        if (!rst_b_i) begin
            ctl_next.prescale = CTL_RESET[PRESCALE_BIT];
            ctl_next.divider = CTL_RESET[DIVIDER_BIT];
            ctl_next.modulus = CTL_RESET[MOD_LSB +: MOD_W];
        end else if (ctl_wr_i && synth_mode_reg) begin
            ctl_next = ctl_wr;
            // Only the loop settings disturb the comparator
            loop_change = (ctl_wr.prescale != ctl_reg.prescale)
                || (ctl_wr.modulus != ctl_reg.modulus);
        end
    end

    always_ff @(posedge clock_i) begin
        ctl_reg <= ctl_next;
    end

    // Feedback path: prescaler then down counter reloaded from the modulus, dividing by modulus plus one
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [MOD_W-1:0] fb_cnt_reg, fb_cnt_next;
    logic fb_pulse_reg, fb_pulse_next;
    logic pre_tick;

    always_comb begin
        pre_tick = ctl_reg.prescale ? (pre_reg == PRE_LAST_W1)
                                    : (pre_reg == PRE_LAST_W0);
        pre_next = pre_tick ? '0 : pre_reg + 3'h1;
        fb_cnt_next = fb_cnt_reg;
        fb_pulse_next = 1'b0;
        if (!rst_b_i || loop_change) begin
            pre_next = '0;
            fb_cnt_next = ctl_next.modulus;
        end else if (pre_tick) begin
            if (fb_cnt_reg == '0) begin
                fb_cnt_next = ctl_reg.modulus;
                fb_pulse_next = synth_mode_reg;
            end else begin
                fb_cnt_next = fb_cnt_reg - 6'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        pre_reg <= pre_next;
        fb_cnt_reg <= fb_cnt_next;
        fb_pulse_reg <= fb_pulse_next;
    end

    // Lock detector: a prescale or modulus change restarts the count of reference edges
    csc_state_e state_reg, state_next;
    logic [LOCK_CNT_W-1:0] lock_cnt_reg, lock_cnt_next;
    logic chip_rel_reg, chip_rel_next;

    always_comb begin
        state_next = state_reg;
        lock_cnt_next = lock_cnt_reg;
        chip_rel_next = chip_rel_reg;
        if (!rst_b_i) begin
            state_next = ST_RELOCK;
            lock_cnt_next = '0;
            chip_rel_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_RELOCK: begin
                    if (!synth_mode_reg) begin
                        state_next = ST_BYPASS;
                    end else if (loop_change) begin
                        lock_cnt_next = '0;
                    end else if (ref_edge) begin
                        if (lock_cnt_reg == LOCK_CNT_W'(LOCK_REF_EDGES - 1)) begin
                            state_next = ST_LOCKED;
                            lock_cnt_next = '0;
                        end else begin
                            lock_cnt_next = lock_cnt_reg + 5'h01;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (loop_change) begin
                        state_next = ST_RELOCK;
                        lock_cnt_next = '0;
                    end
                end
                ST_BYPASS: begin
                    state_next = ST_BYPASS;
                end
            endcase
            // Released once after power-up; later relocks do not reassert it
            if (state_next != ST_RELOCK) begin
                chip_rel_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        state_reg <= state_next;
        lock_cnt_reg <= lock_cnt_next;
        chip_rel_reg <= chip_rel_next;
    end

    // System clock: external pin in bypass, else oscillator stand-in divided by 2 or 4 for even duty
    logic [DIV_W-1:0] div_reg, div_next;
    logic sys_clk_reg, sys_clk_next;

    always_comb begin
        div_next = rst_b_i ? div_reg + 2'h1 : '0;
        if (!synth_mode_reg) begin
            sys_clk_next = ext_s2_reg;
        end else if (ctl_reg.divider) begin
            sys_clk_next = div_reg[0];
        end else begin
            sys_clk_next = div_reg[1];
        end
        if (!rst_b_i) begin
            sys_clk_next = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        div_reg <= div_next;
        sys_clk_reg <= sys_clk_next;
    end

    // Multiplier and read-back; lock bit is driven only by the detector
    logic [MULT_W-1:0] mult_reg, mult_next;
    logic [CTL_W-1:0] rdata_reg, rdata_next;
    logic [2:0] mult_shift;

    always_comb begin
        mult_shift = 3'(MULT_BASE_SHIFT) + {1'b0, ctl_next.prescale, 1'b0}
            + {2'b00, ctl_next.divider};
        mult_next = MULT_W'({1'b0, ctl_next.modulus} + 7'h01) << mult_shift;
        rdata_next = '0;
        rdata_next[PRESCALE_BIT] = ctl_next.prescale;
        rdata_next[DIVIDER_BIT] = ctl_next.divider;
        rdata_next[MOD_LSB +: MOD_W] = ctl_next.modulus;
        rdata_next[LOCK_BIT] = (state_next == ST_LOCKED);
    end

    always_ff @(posedge clock_i) begin
        mult_reg <= mult_next;
        rdata_reg <= rdata_next;
    end

    // Outputs straight from flops
    assign ctl_rdata_o = rdata_reg;
    assign synth_lock_flag_o = rdata_reg[LOCK_BIT];
    assign synth_enabled_o = synth_mode_reg;
    assign chip_reset_b_o = chip_rel_reg;
    assign sys_clock_o = sys_clk_reg;
    assign fb_pulse_o = fb_pulse_reg;
    assign mult_o = mult_reg;

    // Checks
    bypass_no_lock_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !synth_mode_reg |-> !synth_lock_flag_o)
        else $error("lock shown in bypass mode");

    bypass_frozen_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!synth_mode_reg && ctl_wr_i) |=> $stable(ctl_reg))
        else $error("control changed in bypass mode");

    // Reset and divider changes stretch one phase, so both samples need a settled divider
    duty_quarter_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (synth_mode_reg && $past(rst_b_i, 3) && !ctl_reg.divider
            && !$past(ctl_reg.divider) && !$past(ctl_reg.divider, 3))
        |-> sys_clock_o != $past(sys_clock_o, 2))
        else $error("divide by four clock lost its duty cycle");

    duty_half_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (synth_mode_reg && ctl_reg.divider && $past(ctl_reg.divider)
            && $past(ctl_reg.divider, 2))
        |-> sys_clock_o != $past(sys_clock_o))
        else $error("divide by two clock did not toggle");

    lock_count_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(synth_lock_flag_o) |-> $past(lock_cnt_reg, 2) == LOCK_CNT_W'(LOCK_REF_EDGES - 1))
        else $error("lock asserted before relock count");

    relock_drop_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        loop_change |=> !synth_lock_flag_o ##1 !synth_lock_flag_o)
        else $error("lock held across loop change");

    reset_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ($rose(chip_reset_b_o) && synth_mode_reg) |-> synth_lock_flag_o)
        else $error("chip released before lock");

    mult_value_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ##1 mult_o == (MULT_W'({1'b0, ctl_reg.modulus} + 7'h01)
            << (2 + 2 * ctl_reg.prescale + ctl_reg.divider)))
        else $error("multiplier mismatch");

    fb_reload_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (pre_tick && fb_cnt_reg == '0 && !loop_change) |=> fb_cnt_reg == $past(ctl_reg.modulus))
        else $error("feedback counter did not reload");

    prescale_span_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ctl_reg.prescale && pre_tick && !loop_change) |=> !pre_tick [*7])
        else $error("prescaler does not divide by eight");

    reset_value_a: assert property (@(posedge clock_i)
        $rose(rst_b_i) |-> rdata_reg[CTL_W-1:MOD_LSB] == CTL_RESET[CTL_W-1:MOD_LSB])
        else $error("control reset value wrong");

endmodule

// ---- tb/csc_top_tb_top.sv ----
// Self-checking bench for the clock synthesizer control block
`timescale 1ns/1ps
module csc_top_tb_top;
    import csc_pkg::*;
    logic clock_i;
    // Known levels from time zero, so the design never decodes an unknown state
    logic rst_b_i = 1'b0;
    logic mode = 1'b1;
    logic ctl_wr = 1'b0;
    logic ref_clk = 1'b0;
    logic ext_clk = 1'b0;
    logic [CTL_W-1:0] wdata, rdata;
    logic lock, enabled, chip_rst_b, sys_clk, fb_pulse;
    logic [MULT_W-1:0] mult;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int tick = 0;

    csc_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .clock_mode_pin_i(mode),
        .ref_clock_in_i(ref_clk), .ext_sys_clock_i(ext_clk), .ctl_wr_i(ctl_wr),
        .ctl_wdata_i(wdata), .ctl_rdata_o(rdata), .synth_lock_flag_o(lock),
        .synth_enabled_o(enabled), .chip_reset_b_o(chip_rst_b), .sys_clock_o(sys_clk),
        .fb_pulse_o(fb_pulse), .mult_o(mult));

    // Clock, 10 ns period
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Reference period 8 cycles, external clock period 12 cycles
    always @(negedge clock_i) begin
        tick <= tick + 1;
        if (tick % 4 == 3) ref_clk <= ~ref_clk;
        if (tick % 6 == 5) ext_clk <= ~ext_clk;
    end

    // Hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic m);
        @(negedge clock_i);
        rst_b_i = 1'b0;
        mode = m;
        repeat (4) @(negedge clock_i);
        rst_b_i = 1'b1;
    endtask

    // One-cycle write strobe, outputs settle by the next falling edge
    task automatic wr(input logic [15:0] d);
        @(negedge clock_i);
        ctl_wr = 1'b1;
        wdata = d;
        @(negedge clock_i);
        ctl_wr = 1'b0;
    endtask

    task automatic wait_lock(output int n);
        n = 0;
        while (lock !== 1'b1 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
    endtask

    function automatic logic sig(input int which);
        return which == 0 ? sys_clk : fb_pulse;
    endfunction

    // Cycles between two rising edges and cycles spent high
    task automatic period(input int which, output int hi, output int p);
        int g;
        logic prev;
        g = 0;
        hi = 0;
        p = 0;
        prev = 1'b1;
        while (!(prev === 1'b0 && sig(which) === 1'b1) && g < 600) begin
            prev = sig(which);
            @(negedge clock_i);
            g++;
        end
        do begin
            if (sig(which) === 1'b1) hi++;
            prev = sig(which);
            @(negedge clock_i);
            p++;
        end while (!(prev === 1'b0 && sig(which) === 1'b1) && p < 600);
    endtask

    // Power-up in synthesize mode, hold until lock
    task automatic t_powerup();
        int n, hi, p;
        do_reset(1'b1);
        check(rdata, 16'h3F00);
        check(mult, 16'h0100);
        check(enabled, 1'b1);
        repeat (50) @(negedge clock_i);
        check(chip_rst_b, 1'b0);
        check(lock, 1'b0);
        wait_lock(n);
        check(n + 50 >= 116 && n + 50 <= 140, 1'b1);
        check(chip_rst_b, 1'b1);
        check(rdata[LOCK_BIT], 1'b1);
        period(0, hi, p);
        check(p, 4);
        check(hi, 2);
        period(1, hi, p);
        check(p, 128);
    endtask

    // Settings table, lock and unused bits read back as zero
    task automatic t_table();
        logic [15:0] tbl [5] = '{16'h0000, 16'h4000, 16'h8100, 16'hFFFF, 16'h3F00};
        logic [15:0] m [5] = '{16'd4, 16'd8, 16'd32, 16'd2048, 16'd256};
        for (int i = 0; i < 5; i++) begin
            wr(tbl[i]);
            check(rdata, tbl[i] & 16'hFF00);
            check(mult, m[i]);
        end
    endtask

    // Divider bit keeps lock, modulus and prescale changes relock
    task automatic t_relock();
        int n, hi, p;
        wait_lock(n);
        wr(16'h7F00);
        check(lock, 1'b1);
        period(0, hi, p);
        check(p, 2);
        check(hi, 1);
        wr(16'h7E00);
        check(lock, 1'b0);
        check(chip_rst_b, 1'b1);
        wait_lock(n);
        check(n >= 116 && n <= 140, 1'b1);
        period(1, hi, p);
        check(p, 126);
        wr(16'hC208);
        check(rdata, 16'hC200);
        period(1, hi, p);
        check(p, 24);
        check(hi, 1);
    endtask

    // Mode pin low: external clock, writes ignored
    task automatic t_bypass();
        int hi, p;
        do_reset(1'b0);
        check(enabled, 1'b0);
        wr(16'h8100);
        check(rdata, 16'h3F00);
        check(mult, 16'h0100);
        repeat (40) @(negedge clock_i);
        check(lock, 1'b0);
        check(chip_rst_b, 1'b1);
        period(0, hi, p);
        check(p, 12);
        check(hi, 6);
    endtask

    // Main sequence
    initial begin
        rst_b_i = 1'b0;
        mode = 1'b1;
        ctl_wr = 1'b0;
        wdata = 16'h0000;
        t_powerup();
        t_table();
        t_relock();
        t_bypass();
        conclude();
    end
endmodule
